// [rtl/cis_defines.svh]
// Offsets, field positions, reset values and timing counts of the interrupt sequencer
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH
`define CIS_ADDR_W         3
`define CIS_DATA_W         8
`define CIS_OFF_CTRL       3'h0
`define CIS_OFF_CORE_EN    3'h1
`define CIS_OFF_FLAG_ZERO  3'h2
`define CIS_OFF_PERIPH_EN  3'h3
`define CIS_OFF_FLAG_ONE   3'h4
`define CIS_OFF_EVT_STAT   3'h5
`define CIS_OFF_EVT_CLR    3'h6
`define CIS_OFF_EVT_EN     3'h7
`define CIS_BIT_GIE        7
`define CIS_BIT_PERIPHERAL_GROUP_IRQ_ENABLE       6
`define CIS_BIT_EDGE       0
`define CIS_BIT_EXT        0
`define CIS_CTRL_MASK      8'hc1
`define CIS_CORE_MASK      8'h31
`define CIS_RST_CTRL       8'h01
`define CIS_RST_ZERO       8'h00
`define CIS_EVT_TAKEN      0
`define CIS_EVT_RETURN     1
`define CIS_EVT_DEFER      2
`define CIS_EVT_W          3
`define CIS_VECTOR_ADDR    15'h0004
`define CIS_Q_PER_TCY      4
`endif

// [rtl/cis_pkg.sv]
// Types shared by the interrupt sequencer
package cis_pkg;
  typedef enum logic [1:0] {
    CIS_Q1 = 2'b00,
    CIS_Q2 = 2'b01,
    CIS_Q3 = 2'b11,
    CIS_Q4 = 2'b10
  } cis_phase_type;

  typedef enum logic [1:0] {
    CIS_ST_RUN    = 2'b00,
    CIS_ST_FLUSH  = 2'b01,
    CIS_ST_VECTOR = 2'b11
  } cis_state_type;

  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bsr;
    logic [7:0] fsr0_lo;
    logic [7:0] fsr0_hi;
    logic [7:0] fsr1_lo;
    logic [7:0] fsr1_hi;
    logic [7:0] pclath;
  } cis_ctx_type;

  typedef struct packed {
    logic        flush;
    logic        push;
    logic        pop;
    logic        load_pc;
    logic        restore;
    logic [14:0] pc;
  } cis_cpu_cmd_type;
endpackage : cis_pkg

// [rtl/cis_core_irq.sv]
// Interrupt sequencer of the core: flags, enables, entry, return and context shadow
//
// What this block does
// - Every reset leaves all interrupts disabled
// - Vector only with global and source enables
// - Flags set regardless of any enable
// - Entry: flush, clear global, push, save, vector
// - Global clear: flags set, no vectoring
// - Pending interrupt taken once global re-enabled
// - Return pops PC, restores context, sets global
// - Requests sampled only in first quarter-phase
// - Latency three to four instruction cycles
// - Latency independent of instruction length
// - Pin flag set Q4 through Q1, sampled Q1
// - Edge select picks rising or falling pin edge
// - Core enable sources need no group enable
// - Shadow saves whole context, status byte included
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cis_defines.svh"

module cis_core_irq #(
  parameter int NUM_PERIPH = 8
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [`CIS_ADDR_W-1:0]      reg_addr,
  input  wire logic [`CIS_DATA_W-1:0]      reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [`CIS_DATA_W-1:0]      reg_rdata,
  input  wire logic                        ext_pin,
  input  wire logic [1:0]                  core_src_evt,
  input  wire logic [NUM_PERIPH-1:0]       periph_evt,
  input  wire logic                        cpu_return,
  input  wire logic [14:0]                 cpu_pc,
  input  wire cis_pkg::cis_ctx_type        cpu_ctx,
  output cis_pkg::cis_ctx_type             shadow_ctx,
  output cis_pkg::cis_cpu_cmd_type         cpu_cmd,
  output cis_pkg::cis_phase_type           q_phase,
  output logic                             irq_out
);

  cis_pkg::cis_phase_type  q_q, q_d;
  cis_pkg::cis_state_type  st_q, st_d;
  cis_pkg::cis_ctx_type    shadow_q, shadow_d;
  cis_pkg::cis_cpu_cmd_type cmd_q, cmd_d;
  logic [7:0]              ctrl_q, ctrl_d;
  logic [7:0]              core_en_q, core_en_d;
  logic [7:0]              flag0_q, flag0_d;
  logic [NUM_PERIPH-1:0]   pen_q, pen_d;
  logic [NUM_PERIPH-1:0]   flag1_q, flag1_d;
  logic [`CIS_EVT_W-1:0]   evt_q, evt_d;
  logic [`CIS_EVT_W-1:0]   evt_en_q, evt_en_d;
  logic [7:0]              rdata_q, rdata_d;
  logic                    pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0]              pin_arm_q;
  logic                    edge_pend_q, edge_pend_d;
  logic                    pin_edge;
  logic                    core_hit;
  logic                    periph_hit;
  logic                    pending;
  logic                    take;
  logic                    do_return;
  logic [`CIS_EVT_W-1:0]   evt_set;

  // Pads a peripheral vector into a register byte
  function automatic logic [7:0] cis_byte(input logic [NUM_PERIPH-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NUM_PERIPH && i < 8; i++) begin
      r[i] = v[i];
    end
    return r;
  endfunction : cis_byte

  // Pin passes two flip-flops before edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_arm_q <= 3'h0;
    end else begin
      pin_s1_q <= ext_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_arm_q <= {pin_arm_q[1:0], 1'b1};
    end
  end

  // No edge until the synchroniser holds real pin samples, so a high pin is no edge at reset
  assign pin_edge = pin_arm_q[2] & (ctrl_q[`CIS_BIT_EDGE] ? (pin_s2_q & ~pin_s3_q)
                                                          : (~pin_s2_q & pin_s3_q));

  assign core_hit   = |(flag0_q & core_en_q);
  assign periph_hit = ctrl_q[`CIS_BIT_PERIPHERAL_GROUP_IRQ_ENABLE] & (|(flag1_q & pen_q));
  assign pending    = core_hit | periph_hit;
  // Taken only at Q1, only with global enable, only from the run state
  assign take = (q_q == cis_pkg::CIS_Q1) && (st_q == cis_pkg::CIS_ST_RUN)
                && ctrl_q[`CIS_BIT_GIE] && pending;
  assign do_return = cpu_return && (st_q == cis_pkg::CIS_ST_RUN);
  assign evt_set[`CIS_EVT_TAKEN]  = take;
  assign evt_set[`CIS_EVT_RETURN] = do_return;
  assign evt_set[`CIS_EVT_DEFER]  = (q_q == cis_pkg::CIS_Q1) && pending
                                    && !ctrl_q[`CIS_BIT_GIE];

  always_comb begin
    q_d         = q_q;
    st_d        = st_q;
    shadow_d    = shadow_q;
    cmd_d       = '0;
    ctrl_d      = ctrl_q;
    core_en_d   = core_en_q;
    flag0_d     = flag0_q;
    pen_d       = pen_q;
    flag1_d     = flag1_q;
    evt_d       = evt_q;
    evt_en_d    = evt_en_q;
    edge_pend_d = edge_pend_q;
    rdata_d     = 8'h00;
    // Quarter-phase sequencer
    case (q_q)
      cis_pkg::CIS_Q1: q_d = cis_pkg::CIS_Q2;
      cis_pkg::CIS_Q2: q_d = cis_pkg::CIS_Q3;
      cis_pkg::CIS_Q3: q_d = cis_pkg::CIS_Q4;
      default:         q_d = cis_pkg::CIS_Q1;
    endcase
    // Software writes
    if (reg_wr) begin
      if (reg_addr == `CIS_OFF_CTRL) begin
        ctrl_d = reg_wdata & `CIS_CTRL_MASK;
      end else if (reg_addr == `CIS_OFF_CORE_EN) begin
        core_en_d = reg_wdata & `CIS_CORE_MASK;
      end else if (reg_addr == `CIS_OFF_FLAG_ZERO) begin
        flag0_d = reg_wdata & `CIS_CORE_MASK;
      end else if (reg_addr == `CIS_OFF_PERIPH_EN) begin
        pen_d = reg_wdata[NUM_PERIPH-1:0];
      end else if (reg_addr == `CIS_OFF_FLAG_ONE) begin
        flag1_d = reg_wdata[NUM_PERIPH-1:0];
      end else if (reg_addr == `CIS_OFF_EVT_CLR) begin
        evt_d = evt_q & ~reg_wdata[`CIS_EVT_W-1:0];
      end else if (reg_addr == `CIS_OFF_EVT_EN) begin
        evt_en_d = reg_wdata[`CIS_EVT_W-1:0];
      end
    end
    // Reads answer in the next cycle; unmapped reads give zero
    if (reg_rd) begin
      if (reg_addr == `CIS_OFF_CTRL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == `CIS_OFF_CORE_EN) begin
        rdata_d = core_en_q;
      end else if (reg_addr == `CIS_OFF_FLAG_ZERO) begin
        rdata_d = flag0_q;
      end else if (reg_addr == `CIS_OFF_PERIPH_EN) begin
        rdata_d = cis_byte(pen_q);
      end else if (reg_addr == `CIS_OFF_FLAG_ONE) begin
        rdata_d = cis_byte(flag1_q);
      end else if (reg_addr == `CIS_OFF_EVT_STAT) begin
        rdata_d = {5'h00, evt_q};
      end else if (reg_addr == `CIS_OFF_EVT_EN) begin
        rdata_d = {5'h00, evt_en_q};
      end
    end
    // Pin edge held until the Q4-Q1 window
    if (pin_edge) begin
      edge_pend_d = 1'b1;
    end
    if ((q_q == cis_pkg::CIS_Q4 || q_q == cis_pkg::CIS_Q1) && (edge_pend_q || pin_edge)) begin
      flag0_d[`CIS_BIT_EXT] = 1'b1;
      edge_pend_d = 1'b0;
    end
    // Hardware set wins over a software write in the same cycle
    flag0_d[5:4] = flag0_d[5:4] | core_src_evt;
    flag1_d = flag1_d | periph_evt;
    evt_d = evt_d | evt_set;
    // Entry and return sequencing
    case (st_q)
      cis_pkg::CIS_ST_RUN: begin
        if (take) begin
          ctrl_d[`CIS_BIT_GIE] = 1'b0;
          cmd_d.flush = 1'b1;
          cmd_d.push  = 1'b1;
          cmd_d.pc    = cpu_pc;
          shadow_d    = cpu_ctx;
          st_d        = cis_pkg::CIS_ST_FLUSH;
        end else if (do_return) begin
          ctrl_d[`CIS_BIT_GIE] = 1'b1;
          cmd_d.pop     = 1'b1;
          cmd_d.restore = 1'b1;
        end
      end
      cis_pkg::CIS_ST_FLUSH: begin
        // One forced empty cycle whatever the interrupted instruction
        if (q_q == cis_pkg::CIS_Q4) begin
          st_d = cis_pkg::CIS_ST_VECTOR;
        end
      end
      default: begin
        if (q_q == cis_pkg::CIS_Q4) begin
          cmd_d.load_pc = 1'b1;
          cmd_d.pc      = `CIS_VECTOR_ADDR;
          st_d          = cis_pkg::CIS_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_q         <= cis_pkg::CIS_Q1;
      st_q        <= cis_pkg::CIS_ST_RUN;
      shadow_q    <= '0;
      cmd_q       <= '0;
      ctrl_q      <= `CIS_RST_CTRL;
      core_en_q   <= `CIS_RST_ZERO;
      flag0_q     <= `CIS_RST_ZERO;
      pen_q       <= '0;
      flag1_q     <= '0;
      evt_q       <= '0;
      evt_en_q    <= '0;
      rdata_q     <= `CIS_RST_ZERO;
      edge_pend_q <= 1'b0;
    end else begin
      q_q         <= q_d;
      st_q        <= st_d;
      shadow_q    <= shadow_d;
      cmd_q       <= cmd_d;
      ctrl_q      <= ctrl_d;
      core_en_q   <= core_en_d;
      flag0_q     <= flag0_d;
      pen_q       <= pen_d;
      flag1_q     <= flag1_d;
      evt_q       <= evt_d;
      evt_en_q    <= evt_en_d;
      rdata_q     <= rdata_d;
      edge_pend_q <= edge_pend_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign shadow_ctx = shadow_q;
  assign cpu_cmd    = cmd_q;
  assign q_phase    = q_q;
  assign irq_out    = |(evt_q & evt_en_q);

  property p_reset_off;
    @(posedge sys_clk) rst |=> !ctrl_q[`CIS_BIT_GIE] && core_en_q == 8'h00 && pen_q == '0;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables not clear after reset");

  property p_take_enabled;
    @(posedge sys_clk) disable iff (rst)
      cpu_cmd.flush |-> $past(ctrl_q[`CIS_BIT_GIE]) && ($past(|(flag0_q & core_en_q))
               || ($past(ctrl_q[`CIS_BIT_PERIPHERAL_GROUP_IRQ_ENABLE]) && $past(|(flag1_q & pen_q))));
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("entry without enables");

  property p_flag_set;
    @(posedge sys_clk) disable iff (rst) periph_evt[0] |=> flag1_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("peripheral flag not set");

  property p_entry;
    @(posedge sys_clk) disable iff (rst)
      take |=> cpu_cmd.flush && cpu_cmd.push && cpu_cmd.pc == $past(cpu_pc)
               && !ctrl_q[`CIS_BIT_GIE] && shadow_q == $past(cpu_ctx);
  endproperty
  a_entry: assert property (p_entry) else $error("entry steps missing");

  property p_no_take_off;
    @(posedge sys_clk) disable iff (rst) !ctrl_q[`CIS_BIT_GIE] |=> !cpu_cmd.flush;
  endproperty
  a_no_take_off: assert property (p_no_take_off) else $error("vectored while disabled");

  property p_return;
    @(posedge sys_clk) disable iff (rst)
      do_return |=> cpu_cmd.pop && cpu_cmd.restore && ctrl_q[`CIS_BIT_GIE];
  endproperty
  a_return: assert property (p_return) else $error("return steps missing");

  property p_q1_sample;
    @(posedge sys_clk) disable iff (rst) cpu_cmd.flush |-> $past(q_q) == cis_pkg::CIS_Q1;
  endproperty
  a_q1_sample: assert property (p_q1_sample) else $error("request taken outside Q1");

  property p_vector_time;
    @(posedge sys_clk) disable iff (rst)
      take |-> ##8 (cpu_cmd.load_pc && cpu_cmd.pc == `CIS_VECTOR_ADDR);
  endproperty
  a_vector_time: assert property (p_vector_time) else $error("vector not loaded in time");

  property p_pin_edge;
    @(posedge sys_clk) disable iff (rst)
      pin_edge |-> ##[1:4] flag0_q[`CIS_BIT_EXT];
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("pin flag not set after edge");

endmodule : cis_core_irq

// [dv/cis_cpu_model.sv]
// Processor-side model: program counter, context, return stack and return requests
`timescale 1ns/1ps

module cis_cpu_model (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     ld,
  input  wire logic [14:0]              pc_new,
  input  wire cis_pkg::cis_ctx_type     ctx_new,
  input  wire logic                     ret_req,
  input  wire cis_pkg::cis_cpu_cmd_type cpu_cmd,
  input  wire cis_pkg::cis_ctx_type     shadow_ctx,
  output logic [14:0]                   cpu_pc,
  output cis_pkg::cis_ctx_type          cpu_ctx,
  output logic                          cpu_return
);
  logic [14:0] stack[$];

  always @(posedge sys_clk) begin
    cpu_return <= ret_req & ~rst;
    if (rst) begin
      cpu_pc <= 15'h0000;
      cpu_ctx <= '0;
      stack.delete();
    end else if (ld) begin
      cpu_pc <= pc_new;
      cpu_ctx <= ctx_new;
    end else begin
      if (cpu_cmd.push) stack.push_back(cpu_cmd.pc);
      if (cpu_cmd.load_pc) cpu_pc <= cpu_cmd.pc;
      if (cpu_cmd.pop && stack.size() > 0) cpu_pc <= stack.pop_back();
      if (cpu_cmd.restore) cpu_ctx <= shadow_ctx;
    end
  end
endmodule : cis_cpu_model

// [dv/core_interrupt_sequencer_bench.sv]
// Self-checking bench of the core interrupt sequencer
`timescale 1ns/1ps
`include "cis_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module core_interrupt_sequencer_bench;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [2:0]               reg_addr = 3'h0;
  logic [7:0]               reg_wdata = 8'h00;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic                     ext_pin = 1'b0;
  logic [1:0]               core_src_evt = 2'h0;
  logic [7:0]               periph_evt = 8'h00;
  logic                     ld = 1'b0;
  logic [14:0]              pc_new = 15'h0000;
  cis_pkg::cis_ctx_type     ctx_new = '0;
  logic                     ret_req = 1'b0;
  logic [7:0]               reg_rdata;
  logic                     cpu_return;
  logic [14:0]              cpu_pc;
  cis_pkg::cis_ctx_type     cpu_ctx;
  cis_pkg::cis_ctx_type     shadow_ctx;
  cis_pkg::cis_cpu_cmd_type cpu_cmd;
  cis_pkg::cis_phase_type   q_phase;
  cis_pkg::cis_phase_type   q_prev;
  logic                     irq_out;
  logic                     rst_d = 1'b1;
  int                       fails = 0;
  int                       num_checks = 0;
  int                       n_flush = 0;
  int                       nf;
  logic [1:0]               ev;
  logic [7:0]               pm;
  logic [14:0]              pc0;
  cis_pkg::cis_ctx_type     ctx0;

  always #2.5 sys_clk = ~sys_clk;

  cis_core_irq #(.NUM_PERIPH(8)) cis_core_irq_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .core_src_evt(core_src_evt),
    .periph_evt(periph_evt), .cpu_return(cpu_return), .cpu_pc(cpu_pc), .cpu_ctx(cpu_ctx),
    .shadow_ctx(shadow_ctx), .cpu_cmd(cpu_cmd), .q_phase(q_phase), .irq_out(irq_out));

  cis_cpu_model cis_cpu_model_inst (
    .sys_clk(sys_clk), .rst(rst), .ld(ld), .pc_new(pc_new), .ctx_new(ctx_new),
    .ret_req(ret_req), .cpu_cmd(cpu_cmd), .shadow_ctx(shadow_ctx), .cpu_pc(cpu_pc),
    .cpu_ctx(cpu_ctx), .cpu_return(cpu_return));

  function automatic cis_pkg::cis_phase_type nxt(input cis_pkg::cis_phase_type p);
    case (p)
      cis_pkg::CIS_Q1: return cis_pkg::CIS_Q2;
      cis_pkg::CIS_Q2: return cis_pkg::CIS_Q3;
      cis_pkg::CIS_Q3: return cis_pkg::CIS_Q4;
      default: return cis_pkg::CIS_Q1;
    endcase
  endfunction : nxt

  // Phase sequence and take phase watched every cycle
  always @(posedge sys_clk) begin
    #1;
    if (!rst_d) begin
      `CHK("q_phase", nxt(q_prev), q_phase)
      if (cpu_cmd.flush === 1'b1) begin
        n_flush++;
        `CHK("take_phase", cis_pkg::CIS_Q1, q_prev)
      end
    end
    q_prev = q_phase;
    rst_d = rst;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : rd

  task automatic pulse(input logic [1:0] c, input logic [7:0] p);
    @(posedge sys_clk);
    core_src_evt <= c;
    periph_evt <= p;
    @(posedge sys_clk);
    core_src_evt <= 2'h0;
    periph_evt <= 8'h00;
  endtask : pulse

  task automatic load(input logic [14:0] p, input cis_pkg::cis_ctx_type c);
    @(posedge sys_clk);
    ld <= 1'b1;
    pc_new <= p;
    ctx_new <= c;
    @(posedge sys_clk);
    ld <= 1'b0;
  endtask : load

  // Entry: flush and push, then vector load eight cycles after the take
  // Vector code executes one Tcy after the load, when it has been fetched
  task automatic take(input logic [14:0] epc, input cis_pkg::cis_ctx_type ectx);
    int n;
    n = 0;
    #1;
    while (cpu_cmd.flush !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("push_pc", {2'b11, epc}, {cpu_cmd.flush, cpu_cmd.push, cpu_cmd.pc})
    `CHK("shadow", ectx, shadow_ctx)
    repeat (7) @(posedge sys_clk);
    #1;
    `CHK("vector", {1'b1, `CIS_VECTOR_ADDR}, {cpu_cmd.load_pc, cpu_cmd.pc})
    `CHK("latency", 1'b1, (n + 8 + `CIS_Q_PER_TCY) inside {[3 * `CIS_Q_PER_TCY : 4 * `CIS_Q_PER_TCY]})
  endtask : take

  task automatic ret(input logic [14:0] epc, input cis_pkg::cis_ctx_type ectx);
    @(posedge sys_clk);
    ret_req <= 1'b1;
    @(posedge sys_clk);
    ret_req <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("pop_restore", 2'b11, {cpu_cmd.pop, cpu_cmd.restore})
    @(posedge sys_clk);
    #1;
    `CHK("ret_pc", epc, cpu_pc)
    `CHK("ret_ctx", ectx, cpu_ctx)
  endtask : ret

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    #(3000 * 5);
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(32'h14394040));
    idle(2);
    rst <= 1'b0;
    rd(`CIS_OFF_CTRL, `CIS_RST_CTRL, "ctrl_rst");
    rd(`CIS_OFF_CORE_EN, 8'h00, "core_en_rst");
    rd(`CIS_OFF_PERIPH_EN, 8'h00, "periph_en_rst");
    `CHK("irq_rst", 1'b0, irq_out)
    $display("test reset done");
    ev = 2'($urandom_range(3, 1));
    pm = 8'($urandom_range(255, 1));
    nf = n_flush;
    pulse(ev, pm);
    idle(12);
    `CHK("no_take_off", nf, n_flush)
    rd(`CIS_OFF_FLAG_ZERO, {2'b00, ev, 4'h0}, "flag_zero");
    rd(`CIS_OFF_FLAG_ONE, pm, "flag_one");
    wr(`CIS_OFF_FLAG_ZERO, 8'h00);
    wr(`CIS_OFF_FLAG_ONE, 8'h00);
    $display("test flags done");
    pc0 = 15'($urandom);
    ctx0 = {$urandom, $urandom};
    load(pc0, ctx0);
    wr(`CIS_OFF_CORE_EN, 8'h30);
    wr(`CIS_OFF_CTRL, 8'h81);
    pulse(2'b01, 8'h00);
    take(pc0, ctx0);
    rd(`CIS_OFF_CTRL, 8'h01, "global_cleared");
    load(15'h0005, {$urandom, $urandom});
    nf = n_flush;
    pulse(2'b10, 8'h00);
    idle(12);
    `CHK("no_nesting", nf, n_flush)
    rd(`CIS_OFF_FLAG_ZERO, 8'h30, "poll_flags");
    wr(`CIS_OFF_FLAG_ZERO, 8'h00);
    ret(pc0, ctx0);
    rd(`CIS_OFF_CTRL, 8'h81, "global_set");
    $display("test core entry done");
    wr(`CIS_OFF_PERIPH_EN, 8'hff);
    wr(`CIS_OFF_CTRL, 8'h01);
    nf = n_flush;
    pulse(2'b00, pm);
    idle(12);
    wr(`CIS_OFF_CTRL, 8'h81);
    idle(12);
    `CHK("group_gated", nf, n_flush)
    wr(`CIS_OFF_CTRL, 8'hc1);
    take(pc0, ctx0);
    wr(`CIS_OFF_FLAG_ONE, 8'h00);
    ret(pc0, ctx0);
    $display("test peripheral entry done");
    rd(`CIS_OFF_EVT_STAT, 8'h07, "evt_stat");
    wr(`CIS_OFF_EVT_EN, 8'h01);
    #1;
    `CHK("irq_on", 1'b1, irq_out)
    wr(`CIS_OFF_EVT_EN, 8'h00);
    #1;
    `CHK("irq_masked", 1'b0, irq_out)
    wr(`CIS_OFF_EVT_CLR, 8'h07);
    wr(`CIS_OFF_EVT_EN, 8'h07);
    #1;
    `CHK("irq_cleared", 1'b0, irq_out)
    rd(`CIS_OFF_EVT_EN, 8'h07, "evt_en");
    rd(`CIS_OFF_EVT_STAT, 8'h00, "evt_cleared");
    $display("test event register done");
    for (int s = 0; s < 2; s++) begin
      wr(`CIS_OFF_CTRL, {7'h00, s[0]});
      @(posedge sys_clk);
      ext_pin <= s[0];
      idle(8);
      wr(`CIS_OFF_FLAG_ZERO, 8'h00);
      @(posedge sys_clk);
      ext_pin <= ~s[0];
      idle(8);
      rd(`CIS_OFF_FLAG_ZERO, 8'h00, "pin_wrong_edge");
      @(posedge sys_clk);
      ext_pin <= s[0];
      idle(8);
      rd(`CIS_OFF_FLAG_ZERO, 8'h01, "pin_edge");
    end
    $display("test pin edge done");
    wr(`CIS_OFF_CTRL, 8'hc0);
    @(posedge sys_clk);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(`CIS_OFF_CTRL, `CIS_RST_CTRL, "ctrl_rerst");
    idle(8);
    rd(`CIS_OFF_FLAG_ZERO, 8'h00, "no_pin_flag_rerst");
    $display("test second reset done");
    summarize();
  end
endmodule : core_interrupt_sequencer_bench
